// >>> rtl/rtcpc_pkg.sv
// Purpose: Shared constants and types of the calendar power-control block.
// Assumes: One 20 MHz clock, 16-bit register port with 4-bit word address.
// Notes:   Window lengths count calendar timebase ticks.
package rtcpc_pkg;
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned TICK_PERIOD_US  = 1000;
   localparam int unsigned TICK_CYCLES_DEF =
      (CLK_HZ / 1_000_000) * TICK_PERIOD_US;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CNT_W  = 16;
   localparam int unsigned TDIV_W = 24;

   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STAB   = 4'h1;
   localparam logic [3:0] ADDR_SAMP   = 4'h2;
   localparam logic [3:0] ADDR_REST   = 4'h3;
   localparam logic [3:0] ADDR_STAT   = 4'h4;
   localparam logic [3:0] ADDR_CYCLES = 4'h5;

   localparam int unsigned BIT_CAL_EN     = 15;
   localparam int unsigned BIT_PWC_EN     = 10;
   localparam int unsigned BIT_PWC_POL    = 9;
   localparam int unsigned BIT_OPEN_DRAIN = 8;
   localparam int unsigned BIT_PIN_OE     = 7;
   localparam int unsigned BIT_REPEAT     = 6;
   localparam int unsigned SEL_LSB        = 0;
   localparam int unsigned SEL_MSB        = 2;
   localparam logic [2:0]  SEL_PWC        = 3'h3;

   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_STATE_MSB = 2;
   localparam int unsigned STAT_PWR       = 4;
   localparam int unsigned STAT_GATE      = 5;
   localparam int unsigned STAT_PIN       = 6;

   localparam logic [15:0] STAB_RST = 16'h0001;
   localparam logic [15:0] SAMP_RST = 16'h0001;
   localparam logic [15:0] REST_RST = 16'h0001;

   typedef enum logic [2:0] {
      PC_IDLE,
      PC_STABLE,
      PC_SAMPLE,
      PC_REST,
      PC_DONE
   } rtcpc_state_e;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } rtcpc_bus_req_s;

   typedef struct packed {
      logic       cal_en;
      logic       pwc_en;
      logic       pol;
      logic       open_drain;
      logic       pin_oe;
      logic       repeat_en;
      logic [2:0] pin_sel;
   } rtcpc_ctrl_s;
endpackage : rtcpc_pkg

// >>> rtl/rtcpc_top.sv
// Purpose: Autonomous power-up, sample and power-down sequencer for an
//          external device switched from the calendar output pin.
// Assumes: Register port on the same clock; strobes one cycle each.
// Notes:   The pin is two signals; the bench resolves the wire.
//
// How it works
// [RQ1] Sequencer runs only with calendar unit enabled.
// [RQ2] Control bit 10 turns power control on.
// [RQ3] Pin carries signal only when enabled, select 011.
// [RQ4] Control bit 9 chooses active-high or active-low.
// [RQ5] Active-low works with open-drain pin drive.
// [RQ6] Sequence repeats only with periodic repeat set.
// [RQ7] Running sequencer drives power and gate outputs.
// [RQ8] Whole cycle runs with no processor action.
// [RQ9] Power assertion starts the stability window.
// [RQ10] Sample gate asserted through the sample window.
// [RQ11] Sample expiry drops gate and power together.
// [RQ12] Device settles within stability window; gate masks.
// [RQ13] Window lengths are tick counts loaded per assertion.
module rtcpc_top #(
   parameter int unsigned TICK_CYCLES = rtcpc_pkg::TICK_CYCLES_DEF
) (
   input  wire logic                     sys_clk,
   input  wire logic                     resetn,
   input  wire rtcpc_pkg::rtcpc_bus_req_s bus_req,
   output logic [rtcpc_pkg::DATA_W-1:0]  rd_data,
   output logic                          power_ctrl_signal,
   output logic                          sample_gate,
   output logic                          pin_out,
   output logic                          pin_oe
);
   import rtcpc_pkg::*;

   typedef struct packed {
      rtcpc_ctrl_s       ctrl;
      logic [CNT_W-1:0]  stab_len;
      logic [CNT_W-1:0]  samp_len;
      logic [CNT_W-1:0]  rest_len;
      rtcpc_state_e      fsm;
      logic [CNT_W-1:0]  win_cnt;
      logic [TDIV_W-1:0] tick_cnt;
      logic              tick;
      logic [CNT_W-1:0]  cycles;
      logic              pwr_active;
      logic              gate;
      logic              level;
      logic              pin_out;
      logic              pin_oe;
      logic [DATA_W-1:0] rd_data;
   } rtcpc_regs_s;

   localparam logic [TDIV_W-1:0] TICK_LAST =
      TDIV_W'(TICK_CYCLES - 1);

   rtcpc_regs_s q;
   rtcpc_regs_s next_q;

   logic running;
   logic expire;
   logic pin_drive;

   always_comb begin
      next_q  = q;
      next_q.tick    = 1'b0;
      next_q.rd_data = '0;

      // The timebase stops with the calendar unit, so no stale tick can
      // shorten the first window after a re-enable.
      if (!q.ctrl.cal_en) begin
         next_q.tick_cnt = '0;
      end else if (q.tick_cnt >= TICK_LAST) begin
         next_q.tick_cnt = '0;
         next_q.tick     = 1'b1;
      end else begin
         next_q.tick_cnt = q.tick_cnt + TDIV_W'(1);
      end

      if (bus_req.wr) begin
         unique case (bus_req.addr)
            ADDR_CTRL: begin
               next_q.ctrl.cal_en     = bus_req.wdata[BIT_CAL_EN];
               next_q.ctrl.pwc_en     = bus_req.wdata[BIT_PWC_EN];  // [RQ2]
               next_q.ctrl.pol        = bus_req.wdata[BIT_PWC_POL]; // [RQ4]
               next_q.ctrl.open_drain = bus_req.wdata[BIT_OPEN_DRAIN];
               next_q.ctrl.pin_oe     = bus_req.wdata[BIT_PIN_OE];
               next_q.ctrl.repeat_en  = bus_req.wdata[BIT_REPEAT];
               next_q.ctrl.pin_sel    = bus_req.wdata[SEL_MSB:SEL_LSB];
            end
            ADDR_STAB: begin
               next_q.stab_len = bus_req.wdata;
            end
            ADDR_SAMP: begin
               next_q.samp_len = bus_req.wdata;
            end
            ADDR_REST: begin
               next_q.rest_len = bus_req.wdata;
            end
            default: begin
            end
         endcase
      end

      if (bus_req.rd) begin
         unique case (bus_req.addr)
            ADDR_CTRL: begin
               next_q.rd_data[BIT_CAL_EN]      = q.ctrl.cal_en;
               next_q.rd_data[BIT_PWC_EN]      = q.ctrl.pwc_en;
               next_q.rd_data[BIT_PWC_POL]     = q.ctrl.pol;
               next_q.rd_data[BIT_OPEN_DRAIN]  = q.ctrl.open_drain;
               next_q.rd_data[BIT_PIN_OE]      = q.ctrl.pin_oe;
               next_q.rd_data[BIT_REPEAT]      = q.ctrl.repeat_en;
               next_q.rd_data[SEL_MSB:SEL_LSB] = q.ctrl.pin_sel;
            end
            ADDR_STAB: begin
               next_q.rd_data = q.stab_len;
            end
            ADDR_SAMP: begin
               next_q.rd_data = q.samp_len;
            end
            ADDR_REST: begin
               next_q.rd_data = q.rest_len;
            end
            ADDR_STAT: begin
               next_q.rd_data[STAT_STATE_MSB:STAT_STATE_LSB] = q.fsm;
               next_q.rd_data[STAT_PWR]  = q.pwr_active;
               next_q.rd_data[STAT_GATE] = q.gate;
               next_q.rd_data[STAT_PIN]  = q.level;
            end
            ADDR_CYCLES: begin
               next_q.rd_data = q.cycles;
            end
            default: begin
            end
         endcase
      end

      // Both enables must be set; either one dropping aborts at once.
      running = q.ctrl.cal_en & q.ctrl.pwc_en; // [RQ1] [RQ2]
      // A length of zero behaves as one tick so a window never vanishes.
      expire  = q.tick & (q.win_cnt <= CNT_W'(1));

      // No input from the processor side is needed once running.
      if (!running) begin // [RQ8]
         next_q.fsm        = PC_IDLE;
         next_q.pwr_active = 1'b0;
         next_q.gate       = 1'b0;
         next_q.win_cnt    = '0;
      end else begin
         unique case (q.fsm)
            PC_IDLE: begin
               next_q.fsm        = PC_STABLE;           // [RQ7] [RQ9]
               next_q.pwr_active = 1'b1;
               next_q.win_cnt    = q.stab_len;          // [RQ13]
            end
            PC_STABLE: begin
               // The device must be settled by the end of this window.
               if (expire) begin                       // [RQ12]
                  next_q.fsm     = PC_SAMPLE;           // [RQ10]
                  next_q.gate    = 1'b1;
                  next_q.win_cnt = q.samp_len;          // [RQ13]
               end else if (q.tick) begin
                  next_q.win_cnt = q.win_cnt - CNT_W'(1);
               end
            end
            PC_SAMPLE: begin
               if (expire) begin
                  next_q.gate       = 1'b0;             // [RQ11]
                  next_q.pwr_active = 1'b0;             // [RQ11]
                  next_q.cycles     = q.cycles + CNT_W'(1);
                  if (q.ctrl.repeat_en) begin           // [RQ6]
                     next_q.fsm     = PC_REST;
                     next_q.win_cnt = q.rest_len;
                  end else begin
                     next_q.fsm     = PC_DONE;
                     next_q.win_cnt = '0;
                  end
               end else if (q.tick) begin
                  next_q.win_cnt = q.win_cnt - CNT_W'(1);
               end
            end
            PC_REST: begin
               // Clearing repeat during the rest ends the series here.
               if (!q.ctrl.repeat_en) begin             // [RQ6]
                  next_q.fsm     = PC_DONE;
                  next_q.win_cnt = '0;
               end else if (expire) begin
                  next_q.fsm        = PC_STABLE;        // [RQ9]
                  next_q.pwr_active = 1'b1;
                  next_q.win_cnt    = q.stab_len;       // [RQ13]
               end else if (q.tick) begin
                  next_q.win_cnt = q.win_cnt - CNT_W'(1);
               end
            end
            PC_DONE: begin
               // A new single cycle needs either enable cleared and set again.
               next_q.fsm = PC_DONE;
            end
            default: begin
               next_q.fsm        = PC_IDLE;
               next_q.pwr_active = 1'b0;
               next_q.gate       = 1'b0;
            end
         endcase
      end

      next_q.level = next_q.ctrl.pol ? next_q.pwr_active  // [RQ4]
                                     : ~next_q.pwr_active;
      pin_drive = next_q.ctrl.pin_oe &
                  (next_q.ctrl.pin_sel == SEL_PWC);        // [RQ3]
      // Open drain only ever pulls low; the external pull-up supplies the
      // high level, which suits grounding the device directly when the
      // active-low setting is chosen.
      if (!pin_drive) begin
         next_q.pin_out = 1'b0;
         next_q.pin_oe  = 1'b0;
      end else if (next_q.ctrl.open_drain) begin          // [RQ5]
         next_q.pin_out = 1'b0;
         next_q.pin_oe  = ~next_q.level;
      end else begin
         next_q.pin_out = next_q.level;                   // [RQ3]
         next_q.pin_oe  = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         q            <= '0;
         q.stab_len   <= STAB_RST;
         q.samp_len   <= SAMP_RST;
         q.rest_len   <= REST_RST;
         q.fsm        <= PC_IDLE;
         q.level      <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign rd_data           = q.rd_data;
   assign power_ctrl_signal = q.level;  // [RQ7]
   assign sample_gate       = q.gate;   // [RQ7]
   assign pin_out           = q.pin_out;
   assign pin_oe            = q.pin_oe;
endmodule // rtcpc_top

// >>> sim/rtcpc_dev_model.sv
// Purpose: Switched external device that needs time to settle.
// Assumes: pwr high while the device has supply.
// Notes:   Output toggles until settled, so early sampling shows up.
module rtcpc_dev_model #(
   parameter int SETTLE = 3
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic pwr,
   output logic     dev_out,
   output logic     dev_ok
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) cnt <= 0;
      else if (!pwr) cnt <= 0;
      else if (cnt < SETTLE) cnt <= cnt + 1;
   end
   assign dev_ok = (cnt >= SETTLE);
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) dev_out <= 1'b0;
      else dev_out <= dev_ok ? 1'b1 : ~dev_out;
   end
endmodule // rtcpc_dev_model

// >>> sim/rtcpc_top_asserts.sv
// Purpose: Port-level checks of the power-control sequencer.
// Assumes: Control word shadowed from writes seen on the register port.
// Notes:   Checks other than chk_rd_quiet wait one cycle after any control change to settle.
module rtcpc_top_asserts
   import rtcpc_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 4
) (
   input wire logic                      sys_clk,
   input wire logic                      resetn,
   input wire rtcpc_pkg::rtcpc_bus_req_s bus_req,
   input wire logic [rtcpc_pkg::DATA_W-1:0] rd_data,
   input wire logic                      power_ctrl_signal,
   input wire logic                      sample_gate,
   input wire logic                      pin_out,
   input wire logic                      pin_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   struct packed {rtcpc_ctrl_s cur; rtcpc_ctrl_s prv;} st, next_st;
   logic en, steady, sel_ok, act;
   int unsigned gate_len;
   always_comb begin
      next_st = st;
      next_st.prv = st.cur;
      if (bus_req.wr && bus_req.addr == ADDR_CTRL) begin
         next_st.cur = {bus_req.wdata[BIT_CAL_EN],
                        bus_req.wdata[BIT_PWC_EN:BIT_REPEAT],
                        bus_req.wdata[SEL_MSB:SEL_LSB]};
      end
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) st <= '0;
      else st <= next_st;
   end
   assign en     = st.cur.cal_en & st.cur.pwc_en;
   assign steady = (st.cur == st.prv);
   assign sel_ok = st.cur.pin_oe && st.cur.pin_sel == SEL_PWC;
   assign act    = (power_ctrl_signal == st.cur.pol);
   // The gate opens and closes on timebase ticks, so its length in clocks
   // must be a whole number of ticks; counting it catches a skewed window.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gate_len <= 0;
      end else if (sample_gate) begin
         gate_len <= gate_len + 1;
      end else begin
         gate_len <= 0;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   chk_idle_off: assert property (
      steady && !en |-> !sample_gate && !act)
      else $error("sequencer active while disabled");
   chk_pin_off: assert property (
      steady && !sel_ok |-> !pin_oe && !pin_out)
      else $error("pin driven without power select");
   chk_push_pull: assert property (
      steady && sel_ok && !st.cur.open_drain
      |-> pin_oe && pin_out == power_ctrl_signal)
      else $error("push-pull pin wrong");
   chk_open_drain: assert property (
      steady && sel_ok && st.cur.open_drain
      |-> !pin_out && pin_oe == !power_ctrl_signal)
      else $error("open-drain pin wrong");
   chk_gate_power: assert property (
      steady && sample_gate |-> act)
      else $error("gate open while power off");
   chk_stab_first: assert property (
      steady && $rose(act) |-> !sample_gate)
      else $error("gate open at power-up");
   chk_gate_drop: assert property (
      steady && en && $fell(sample_gate) |-> !act)
      else $error("power held after sample window");
   chk_power_drop: assert property (
      steady && en && $fell(act) |-> $past(sample_gate))
      else $error("power dropped outside sample window");
   chk_no_repeat: assert property (
      steady && en && !st.cur.repeat_en && $fell(sample_gate)
      |=> (!act) [*8])
      else $error("sequence repeated without repeat");
   chk_gate_ticks: assert property (
      steady && en && $fell(sample_gate)
      |-> gate_len != 0 && gate_len % TICK_CYCLES == 0)
      else $error("sample window not whole ticks");
   chk_rd_quiet: assert property (!$past(bus_req.rd) |-> rd_data == '0)
      else $error("read data outside read slot");
endmodule // rtcpc_top_asserts

bind rtcpc_top rtcpc_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req),
   .rd_data(rd_data), .power_ctrl_signal(power_ctrl_signal),
   .sample_gate(sample_gate), .pin_out(pin_out), .pin_oe(pin_oe));

// >>> sim/rtcpc_top_tb.sv
// Purpose: Register-driven tests of the power-control sequencer.
// Assumes: Short tick divider so windows last a dozen cycles or fewer.
// Notes:   The pin wire has a pull-up for the open-drain case.
module rtcpc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rtcpc_pkg::*;
   logic           sys_clk = 1'b0;
   logic           resetn = 1'b0;
   rtcpc_bus_req_s req = '0;
   logic [15:0]    rd_data, v;
   logic           pwr, gate, pin_out, pin_oe, dev_out, dev_ok;
   logic           act_hi = 1'b1;
   int             mismatches = 0;
   int             compares = 0;
   int             waited = 0;
   localparam int  TICKS = 4;
   logic [3:0]     ra [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf};
   logic [15:0]    re [7] = '{16'h0, 16'h1, 16'h1, 16'h1, 16'h0, 16'h0, 16'h0};
   wire logic      pin_wire = pin_oe ? pin_out : 1'b1;
   always #25 sys_clk = ~sys_clk;
   rtcpc_top #(.TICK_CYCLES(TICKS)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
      .bus_req(req), .rd_data(rd_data), .power_ctrl_signal(pwr),
      .sample_gate(gate), .pin_out(pin_out), .pin_oe(pin_oe));
   rtcpc_dev_model u_dev (.sys_clk(sys_clk), .resetn(resetn),
      .pwr(pin_wire ~^ act_hi), .dev_out(dev_out), .dev_ok(dev_ok));
   task automatic chk(input string n, input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask
   task automatic rchk(input string n, input logic [3:0] a,
                       input logic [15:0] m, e);
      @(posedge sys_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 v = rd_data;
      chk(n, v & m, e);
   endtask
   // Bounded wait; a gate that never moves shows up as a mismatch.
   // The cycles spent waiting are kept so window lengths can be checked.
   task automatic wait_gate(input logic lvl);
      waited = 0;
      while (waited < 200 && gate !== lvl) begin
         step(1);
         waited++;
      end
      chk("gate", gate, lvl);
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rchk("reg", ra[i], 16'hffbf, re[i]);
      end
      wr(ADDR_STAT, 16'hffff);
      wr(ADDR_CYCLES, 16'hffff);
      rchk("status ro", ADDR_STAT, 16'hffff, 16'h0040);
      rchk("cycles ro", ADDR_CYCLES, 16'hffff, 16'h0000);
      $display("test reset values done");
      wr(ADDR_STAB, 16'h0002);
      wr(ADDR_SAMP, 16'h0003);
      wr(ADDR_CTRL, 16'h86c3);
      step(1);
      chk("power up", {gate, pwr, pin_oe, pin_out}, 16'h7);
      wait_gate(1'b1);
      // Two stability ticks; the first tick may come early in its period.
      v = 16'(waited > TICKS && waited <= 2 * TICKS);
      chk("stab window", v, 16'h1);
      chk("settled", {dev_out, dev_ok, pwr}, 16'h7);
      wait_gate(1'b0);
      chk("samp window", 16'(waited), 16'(3 * TICKS));
      chk("power down", pwr, 1'b0);
      rchk("cycles", ADDR_CYCLES, 16'hffff, 16'h0001);
      wait_gate(1'b1);
      // One rest tick and two stability ticks, less the two read cycles.
      chk("rest gap", 16'(waited), 16'(3 * TICKS - 2));
      rchk("sampling", ADDR_STAT, 16'h0077, 16'h0072);
      $display("test push-pull repeat done");
      wr(ADDR_CTRL, 16'h06c3);
      step(1);
      chk("abort", {gate, pwr}, 16'h0);
      wr(ADDR_CTRL, 16'h82c3);
      step(20);
      chk("no start", {gate, pwr}, 16'h0);
      $display("test disable done");
      act_hi = 1'b0;
      wr(ADDR_CTRL, 16'h8583);
      step(1);
      chk("od on", {pwr, pin_oe, pin_out}, 16'h2);
      wait_gate(1'b1);
      v = 16'(waited > TICKS && waited <= 2 * TICKS);
      chk("od stab", v, 16'h1);
      chk("od settled", {dev_out, dev_ok}, 16'h3);
      wait_gate(1'b0);
      chk("od samp", 16'(waited), 16'(3 * TICKS));
      chk("od off", {pwr, pin_oe}, 16'h2);
      step(40);
      chk("single", gate, 1'b0);
      rchk("done", ADDR_STAT, 16'h0077, 16'h0044);
      $display("test open-drain single done");
      wr(ADDR_CTRL, 16'h8584);
      step(1);
      chk("pin off", {pin_oe, pin_out}, 16'h0);
      $display("test pin select done");
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      step(1);
      chk("reset pins", {gate, pwr, pin_oe, pin_out}, 16'h4);
      rchk("reset ctrl", ADDR_CTRL, 16'hffff, 16'h0000);
      $display("test mid-run reset done");
      finish_test();
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      mismatches++;
      finish_test();
   end
endmodule // rtcpc_top_tb
